//--- design/boam_pkg.sv
// Constants and types for the operand and effective-address unit.
// Assumes a byte-wide instruction queue and a byte-wide memory read port.
// Contract
// - Immediate operands arrive through the queue from program fetches, not data reads.
// - An immediate operand is taken from queued bytes; no memory access is made.
// - The opcode alone sets operand width: one byte or two bytes.
// - Direct mode: one byte is the low address, upper byte forced zero.
// - A 16-bit direct load reads two bytes: first to upper half, next to lower.
// - Extended mode: two instruction bytes form the whole 16-bit address.
// - Short branch is an opcode byte plus one signed displacement byte.
// - Long branch is prefix, opcode, then a signed 16-bit displacement.
// - Condition met: target is next address plus displacement; else fall through.
// - Mask test: set variant needs masked bits one, clear variant needs them zero.
// - Bit branch: operand by its address mode, mask immediate, target relative.
// - Short displacement is sign-extended, range -128 to +127.
// - Long displacement is a signed 16-bit value, -32768 to +32767.
// - Zero displacement always continues with the next instruction.
// - Short always-branch of -2 or long of -4 loops onto itself.
// - Bit branch looping onto its own opcode repeats while its test is satisfied.
// - Multi-byte memory values are big-endian with no alignment need.
// - Address forming adds no cycles beyond the memory reference.
package boam_pkg;

  localparam logic [7:0]  OPC_LD8_IMM     = 8'h86;
  localparam logic [7:0]  OPC_LD8_DIR     = 8'h96;
  localparam logic [7:0]  OPC_LD8_EXT     = 8'hb6;
  localparam logic [7:0]  OPC_LD16_IMM    = 8'hce;
  localparam logic [7:0]  OPC_LD16_DIR    = 8'hde;
  localparam logic [7:0]  OPC_LD16_EXT    = 8'hfe;
  localparam logic [7:0]  OPC_BSET_DIR    = 8'h4e;
  localparam logic [7:0]  OPC_BCLR_DIR    = 8'h4f;
  localparam logic [7:0]  OPC_BSET_EXT    = 8'h1e;
  localparam logic [7:0]  OPC_BCLR_EXT    = 8'h1f;
  localparam logic [7:0]  OPC_LONG_PREFIX = 8'h18;
  localparam logic [3:0]  BR_GROUP        = 4'h2;

  localparam logic [1:0]  N_BYTE          = 2'h1;
  localparam logic [1:0]  N_WORD          = 2'h2;
  localparam logic [7:0]  ZP_HI           = 8'h00;
  localparam logic [15:0] PC_RST          = 16'h0000;
  localparam logic [15:0] ONE16           = 16'h0001;

  localparam int          C_BIT           = 0;
  localparam int          V_BIT           = 1;
  localparam int          Z_BIT           = 2;
  localparam int          N_BIT           = 3;

  localparam logic [2:0]  TST_ALWAYS      = 3'h0;
  localparam logic [2:0]  TST_HI          = 3'h1;
  localparam logic [2:0]  TST_CC          = 3'h2;
  localparam logic [2:0]  TST_NE          = 3'h3;
  localparam logic [2:0]  TST_VC          = 3'h4;
  localparam logic [2:0]  TST_PL          = 3'h5;
  localparam logic [2:0]  TST_GE          = 3'h6;
  localparam logic [2:0]  TST_GT          = 3'h7;

  typedef enum logic [2:0] {
    ST_OPC, ST_OPC2, ST_ADDR, ST_IMM, ST_MASK, ST_DISP, ST_RDHI, ST_RDLO
  } boam_state_t;

  typedef enum logic [1:0] {
    MD_IMMEDIATE_MODE, MD_DIRECT_MODE, MD_FULL_ADDRESS_MODE, MD_RELATIVE_MODE
  } boam_mode_t;

  typedef enum logic [2:0] {
    CL_LOAD8, CL_LOAD_FIRST_INDEX_REG, CL_SHORT_BRANCH, CL_LONG_BRANCH,
    CL_BRANCH_IF_MASK_BITS_SET, CL_BRANCH_IF_MASK_BITS_CLEAR
  } boam_class_t;

endpackage

//--- design/boam_core.sv
// Operand fetch, effective address and branch target unit.
// Assumes a byte queue that pops on q_take and a memory port that
// answers each read with mem_ack while mem_rd is high.
module boam_core (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        pc_set,
  input  wire logic [15:0] pc_set_val,
  input  wire logic        q_valid,
  input  wire logic [7:0]  q_data,
  input  wire logic [3:0]  ccr_flags,
  input  wire logic        mem_ack,
  input  wire logic [7:0]  mem_rdata,
  output wire logic        q_take,
  output wire logic        mem_rd,
  output wire logic [15:0] mem_addr,
  output wire logic [15:0] pc,
  output wire logic [7:0]  acc8,
  output wire logic [15:0] idx16,
  output wire logic        br_taken,
  output wire logic        redirect,
  output wire logic        instr_done,
  output wire logic        bad_opcode
);

  boam_pkg::boam_state_t st_r;
  boam_pkg::boam_mode_t  mode_r;
  boam_pkg::boam_class_t cls_r;
  logic [1:0]            cnt_r;
  logic [15:0]           sh_r;
  logic [15:0]           addr_r;
  logic [7:0]            mask_r;
  logic [15:0]           disp_r;
  logic [7:0]            opc_r;
  logic [7:0]            hi_r;
  logic                  q_take_r;
  logic                  mem_rd_r;
  logic [15:0]           mem_addr_r;
  logic [15:0]           pc_r;
  logic [7:0]            acc8_r;
  logic [15:0]           idx16_r;
  logic                  br_taken_r;
  logic                  redirect_r;
  logic                  done_r;
  logic                  bad_r;
  logic                  byte_st;
  logic                  take;
  logic                  last;
  logic                  is_bit;
  logic                  is_ld16;
  logic [15:0]           word;
  logic [15:0]           ea;
  logic [15:0]           disp_now;
  logic                  dec_ok;
  boam_pkg::boam_class_t dec_cls;
  boam_pkg::boam_mode_t  dec_mode;
  logic [1:0]            dec_cnt;
  boam_pkg::boam_state_t dec_st;
  logic                  fire;
  logic                  hit;
  logic [15:0]           base;
  logic [15:0]           bdisp;
  logic [15:0]           target;
  logic                  rd_start;
  logic                  rd_next;
  logic                  done;
  logic [7:0]            masked;
  function automatic logic cond_met(input logic [3:0] cc,
                                    input logic [3:0] f);
    logic t;
    case (cc[3:1])
      boam_pkg::TST_ALWAYS: t = 1'b1;
      boam_pkg::TST_HI: t = ~(f[boam_pkg::C_BIT] | f[boam_pkg::Z_BIT]);
      boam_pkg::TST_CC: t = ~f[boam_pkg::C_BIT];
      boam_pkg::TST_NE: t = ~f[boam_pkg::Z_BIT];
      boam_pkg::TST_VC: t = ~f[boam_pkg::V_BIT];
      boam_pkg::TST_PL: t = ~f[boam_pkg::N_BIT];
      boam_pkg::TST_GE: t = ~(f[boam_pkg::N_BIT] ^ f[boam_pkg::V_BIT]);
      boam_pkg::TST_GT:
        t = ~(f[boam_pkg::Z_BIT] |
              (f[boam_pkg::N_BIT] ^ f[boam_pkg::V_BIT]));
      default: t = 1'b1;
    endcase
    // Odd codes test the opposite condition
    return t ^ cc[0];
  endfunction
  assign q_take     = q_take_r;
  assign mem_rd     = mem_rd_r;
  assign mem_addr   = mem_addr_r;
  assign pc         = pc_r;
  assign acc8       = acc8_r;
  assign idx16      = idx16_r;
  assign br_taken   = br_taken_r;
  assign redirect   = redirect_r;
  assign instr_done = done_r;
  assign bad_opcode = bad_r;
  // Operand bytes come only from the queue; at most one pop per two cycles
  assign byte_st = (st_r == boam_pkg::ST_OPC) || (st_r == boam_pkg::ST_OPC2)
                || (st_r == boam_pkg::ST_ADDR) || (st_r == boam_pkg::ST_IMM)
                || (st_r == boam_pkg::ST_MASK) || (st_r == boam_pkg::ST_DISP);
  assign take    = byte_st && q_valid && !q_take_r && !pc_set;
  assign last    = (cnt_r == boam_pkg::N_BYTE);
  assign is_bit  = (cls_r == boam_pkg::CL_BRANCH_IF_MASK_BITS_SET) ||
                   (cls_r == boam_pkg::CL_BRANCH_IF_MASK_BITS_CLEAR);
  assign is_ld16 = (cls_r == boam_pkg::CL_LOAD_FIRST_INDEX_REG);
  // First queued byte is the more significant one
  assign word    = {sh_r[7:0], q_data};
  assign ea      = (mode_r == boam_pkg::MD_DIRECT_MODE) ?
                   {boam_pkg::ZP_HI, q_data} :
                   word;
  assign disp_now = (cls_r == boam_pkg::CL_LONG_BRANCH) ?
                    word :
                    {{8{q_data[7]}}, q_data};

  // Width and mode come from the opcode byte alone
  always_comb begin
    dec_ok   = 1'b1;
    dec_cls  = boam_pkg::CL_LOAD8;
    dec_mode = boam_pkg::MD_IMMEDIATE_MODE;
    dec_cnt  = boam_pkg::N_BYTE;
    dec_st   = boam_pkg::ST_IMM;
    case (q_data)
      boam_pkg::OPC_LD8_IMM: dec_cnt = boam_pkg::N_BYTE;
      boam_pkg::OPC_LD16_IMM: begin
        dec_cls = boam_pkg::CL_LOAD_FIRST_INDEX_REG;
        dec_cnt = boam_pkg::N_WORD;
      end
      boam_pkg::OPC_LD8_DIR, boam_pkg::OPC_LD16_DIR: begin
        dec_mode = boam_pkg::MD_DIRECT_MODE;
        dec_st   = boam_pkg::ST_ADDR;
      end
      boam_pkg::OPC_LD8_EXT, boam_pkg::OPC_LD16_EXT: begin
        dec_mode = boam_pkg::MD_FULL_ADDRESS_MODE;
        dec_cnt  = boam_pkg::N_WORD;
        dec_st   = boam_pkg::ST_ADDR;
      end
      boam_pkg::OPC_BSET_DIR, boam_pkg::OPC_BCLR_DIR: begin
        dec_mode = boam_pkg::MD_DIRECT_MODE;
        dec_st   = boam_pkg::ST_ADDR;
      end
      boam_pkg::OPC_BSET_EXT, boam_pkg::OPC_BCLR_EXT: begin
        dec_mode = boam_pkg::MD_FULL_ADDRESS_MODE;
        dec_cnt  = boam_pkg::N_WORD;
        dec_st   = boam_pkg::ST_ADDR;
      end
      default: begin
        if (q_data[7:4] == boam_pkg::BR_GROUP) begin
          dec_cls  = boam_pkg::CL_SHORT_BRANCH;
          dec_mode = boam_pkg::MD_RELATIVE_MODE;
          dec_st   = boam_pkg::ST_DISP;
        end else
          dec_ok = 1'b0;
      end
    endcase
    if (q_data == boam_pkg::OPC_LD16_DIR || q_data == boam_pkg::OPC_LD16_EXT)
      dec_cls = boam_pkg::CL_LOAD_FIRST_INDEX_REG;
    if (q_data == boam_pkg::OPC_BSET_DIR || q_data == boam_pkg::OPC_BSET_EXT)
      dec_cls = boam_pkg::CL_BRANCH_IF_MASK_BITS_SET;
    if (q_data == boam_pkg::OPC_BCLR_DIR || q_data == boam_pkg::OPC_BCLR_EXT)
      dec_cls = boam_pkg::CL_BRANCH_IF_MASK_BITS_CLEAR;
  end

  // Branch resolution, from the last displacement byte or the tested byte
  assign masked = mem_rdata & mask_r;
  always_comb begin
    fire  = 1'b0;
    hit   = 1'b0;
    base  = pc_r;
    bdisp = disp_r;
    if (st_r == boam_pkg::ST_DISP && take && last && !is_bit) begin
      fire  = 1'b1;
      hit   = cond_met(opc_r[3:0], ccr_flags);
      base  = pc_r + boam_pkg::ONE16;
      bdisp = disp_now;
    end else if (st_r == boam_pkg::ST_RDHI && mem_ack && is_bit) begin
      fire = 1'b1;
      if (cls_r == boam_pkg::CL_BRANCH_IF_MASK_BITS_SET)
        hit = (masked == mask_r);
      else
        hit = (masked == 8'h00);
    end
  end
  // Wraps around the address space
  assign target = base + bdisp;
  assign rd_start = take && last &&
                    ((st_r == boam_pkg::ST_ADDR && !is_bit) ||
                     (st_r == boam_pkg::ST_DISP && is_bit));
  assign rd_next  = (st_r == boam_pkg::ST_RDHI) && mem_ack && is_ld16;
  assign done = (st_r == boam_pkg::ST_IMM && take && last) ||
                (st_r == boam_pkg::ST_DISP && take && last && !is_bit) ||
                (st_r == boam_pkg::ST_RDHI && mem_ack && !is_ld16) ||
                (st_r == boam_pkg::ST_RDLO && mem_ack);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_r   <= boam_pkg::ST_OPC;
      mode_r <= boam_pkg::MD_IMMEDIATE_MODE;
      cls_r  <= boam_pkg::CL_LOAD8;
      cnt_r  <= 2'h0;
      sh_r   <= 16'h0000;
      addr_r <= 16'h0000;
      mask_r <= 8'h00;
      disp_r <= 16'h0000;
      opc_r  <= 8'h00;
      hi_r   <= 8'h00;
    end else if (pc_set)
      st_r <= boam_pkg::ST_OPC;
    else begin
      if (take)
        sh_r <= word;
      case (st_r)
        boam_pkg::ST_OPC: if (take) begin
          opc_r <= q_data;
          if (q_data == boam_pkg::OPC_LONG_PREFIX)
            st_r <= boam_pkg::ST_OPC2;
          else if (dec_ok) begin
            cls_r  <= dec_cls;
            mode_r <= dec_mode;
            cnt_r  <= dec_cnt;
            st_r   <= dec_st;
          end
        end
        boam_pkg::ST_OPC2: if (take) begin
          opc_r <= q_data;
          if (q_data[7:4] == boam_pkg::BR_GROUP) begin
            cls_r  <= boam_pkg::CL_LONG_BRANCH;
            mode_r <= boam_pkg::MD_RELATIVE_MODE;
            cnt_r  <= boam_pkg::N_WORD;
            st_r   <= boam_pkg::ST_DISP;
          end else
            st_r <= boam_pkg::ST_OPC;
        end
        boam_pkg::ST_ADDR: if (take) begin
          cnt_r <= cnt_r - boam_pkg::N_BYTE;
          if (last) begin
            addr_r <= ea;
            // Bit branch: operand address, then mask, then displacement
            st_r <= is_bit ? boam_pkg::ST_MASK :
                             boam_pkg::ST_RDHI;
          end
        end
        boam_pkg::ST_IMM: if (take) begin
          cnt_r <= cnt_r - boam_pkg::N_BYTE;
          if (last)
            st_r <= boam_pkg::ST_OPC;
        end
        boam_pkg::ST_MASK: if (take) begin
          mask_r <= q_data;
          cnt_r  <= boam_pkg::N_BYTE;
          st_r   <= boam_pkg::ST_DISP;
        end
        boam_pkg::ST_DISP: if (take) begin
          cnt_r <= cnt_r - boam_pkg::N_BYTE;
          if (last) begin
            disp_r <= disp_now;
            st_r   <= is_bit ? boam_pkg::ST_RDHI : boam_pkg::ST_OPC;
          end
        end
        boam_pkg::ST_RDHI: if (mem_ack) begin
          hi_r <= mem_rdata;
          st_r <= is_ld16 ? boam_pkg::ST_RDLO : boam_pkg::ST_OPC;
        end
        boam_pkg::ST_RDLO: if (mem_ack)
          st_r <= boam_pkg::ST_OPC;
        default: st_r <= boam_pkg::ST_OPC;
      endcase
    end
  end

  // Queue pop strobe; immediates never touch the memory port
  always_ff @(posedge sys_clk) begin
    if (!nrst)
      q_take_r <= 1'b0;
    else
      q_take_r <= take;
  end

  // Memory read: address leaves with the last address byte (the last displacement byte for bit branches), no dead cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mem_rd_r   <= 1'b0;
      mem_addr_r <= 16'h0000;
    end else if (pc_set)
      mem_rd_r <= 1'b0;
    else if (rd_start) begin
      mem_rd_r   <= 1'b1;
      mem_addr_r <= (st_r == boam_pkg::ST_ADDR) ? ea : addr_r;
    end else if (rd_next)
      mem_addr_r <= mem_addr_r + boam_pkg::ONE16;
    else if (mem_ack)
      mem_rd_r <= 1'b0;
  end

  // Load results
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      acc8_r  <= 8'h00;
      idx16_r <= 16'h0000;
    end else if (st_r == boam_pkg::ST_IMM && take && last) begin
      if (is_ld16)
        idx16_r <= word;
      else
        acc8_r <= q_data;
    end else if (st_r == boam_pkg::ST_RDHI && mem_ack &&
                 cls_r == boam_pkg::CL_LOAD8)
      acc8_r <= mem_rdata;
    else if (st_r == boam_pkg::ST_RDLO && mem_ack)
      idx16_r <= {hi_r, mem_rdata};
  end

  // Program counter follows every popped byte or a taken branch
  always_ff @(posedge sys_clk) begin
    if (!nrst)
      pc_r <= boam_pkg::PC_RST;
    else if (pc_set)
      pc_r <= pc_set_val;
    else if (fire && hit)
      pc_r <= target;
    else if (take)
      pc_r <= pc_r + boam_pkg::ONE16;
  end

  // Status pulses; a zero displacement needs no queue flush
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      br_taken_r <= 1'b0;
      redirect_r <= 1'b0;
      done_r     <= 1'b0;
      bad_r      <= 1'b0;
    end else begin
      br_taken_r <= fire && hit && !pc_set;
      redirect_r <= fire && hit && !pc_set &&
                    (target != base);
      done_r     <= done && !pc_set;
      bad_r      <= take &&
                    ((st_r == boam_pkg::ST_OPC && !dec_ok &&
                      q_data != boam_pkg::OPC_LONG_PREFIX) ||
                     (st_r == boam_pkg::ST_OPC2 &&
                      q_data[7:4] != boam_pkg::BR_GROUP));
    end
  end

endmodule

//--- test/boam_core_assertions.sv
// Port-level checker for the operand and address unit.
// Assumes one clock, sys_clk, and a synchronous active-low nrst.
module boam_checker (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        pc_set,
  input wire logic        q_valid,
  input wire logic        q_take,
  input wire logic        mem_rd,
  input wire logic        mem_ack,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] pc,
  input wire logic        br_taken,
  input wire logic        redirect,
  input wire logic        instr_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_take_spacing: assert property (q_take |=> !q_take)
    else $error("queue popped on two cycles in a row");
  a_take_offered: assert property (
    q_take |-> $past(q_valid && !pc_set && nrst))
    else $error("queue popped without an offered byte");
  a_wait_no_take: assert property (
    (mem_rd && $past(mem_rd)) |-> !q_take)
    else $error("queue popped during a memory wait");
  a_rd_holds_addr: assert property (
    (mem_rd && !mem_ack && !pc_set) |=> (mem_rd && $stable(mem_addr)))
    else $error("read request or address moved before ack");
  a_wide_next_addr: assert property (
    (mem_rd && mem_ack && !pc_set) |=>
      (!mem_rd || mem_addr == $past(mem_addr) + 16'h0001))
    else $error("second read is not at the next address");
  a_done_after_ack: assert property (
    (mem_rd && mem_ack && !pc_set) |=> (mem_rd || instr_done))
    else $error("instruction did not finish after last ack");
  a_done_no_read: assert property (instr_done |-> !mem_rd)
    else $error("read still pending at completion");
  a_redirect_taken: assert property (
    redirect |-> (br_taken && instr_done))
    else $error("redirect without a taken, finished branch");
  a_redirect_moves: assert property (
    redirect |-> pc != ($past(mem_ack && mem_rd) ? $past(pc)
                                                  : $past(pc) + 16'h0001))
    else $error("redirect to the sequential address");
  a_flush_no_take: assert property (redirect |=> !q_take)
    else $error("queue popped during a redirect flush");
endmodule

//--- test/boam_partner.sv
// Model of the instruction queue and byte-wide memory read port.
// Assumes the unit redirects the queue by pc on redirect, or by pc_set_val on pc_set.
module boam_partner (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        pc_set,
  input  wire logic [15:0] pc_set_val,
  input  wire logic        q_take,
  input  wire logic        redirect,
  input  wire logic [15:0] pc,
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  output wire logic        q_valid,
  output wire logic [7:0]  q_data,
  output logic             mem_ack,
  output logic [7:0]       mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:65535];
  logic [15:0] ptr_r;
  logic [1:0]  wait_r;
  logic        stall_r;

  initial foreach (mem[i]) mem[i] = 8'h00;

  // Program fetch path: operands arrive with the instruction bytes
  // Nothing is offered while the queue flushes for a redirect
  assign q_valid = !stall_r && !redirect;
  assign q_data  = q_valid ? mem[ptr_r] : ~mem[ptr_r];

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ptr_r   <= 16'h0000;
      stall_r <= 1'b1;
    end else begin
      stall_r <= ($urandom % 4) == 0;
      if (pc_set) ptr_r <= pc_set_val;
      else if (redirect) ptr_r <= pc;
      else if (q_take) ptr_r <= ptr_r + 16'h0001;
    end
  end

  // Reads answered after 0 to 3 wait cycles, big-endian byte store
  always_ff @(posedge sys_clk) begin
    mem_rdata <= ~mem_rdata;
    if (!nrst || !mem_rd || mem_ack) begin
      mem_ack <= 1'b0;
      wait_r  <= 2'($urandom);
    end else if (wait_r == 2'h0) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem[mem_addr];
    end else begin
      wait_r <= wait_r - 2'h1;
    end
  end
endmodule

//--- test/tb_basic_operand_address_modes.sv
// Self-checking bench for the operand and address unit.
// Assumes boam_partner serves the queue and the memory reads.
module tb_basic_operand_address_modes;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, nrst, pc_set, q_valid, q_take, mem_ack, mem_rd;
  logic        br_taken, redirect, instr_done, bad_opcode, eb, er;
  logic [15:0] pc_set_val, mem_addr, pc, idx16, a, a_fix, ev, epc, eadr;
  logic [15:0] ack_addr_r;
  logic [7:0]  q_data, mem_rdata, acc8;
  logic [7:0]  b [6];
  logic [3:0]  ccr_flags;
  int          fails, samples_checked, acks, n, kd, ea, i;

  boam_core dut_u (.sys_clk, .nrst, .pc_set, .pc_set_val, .q_valid, .q_data,
    .ccr_flags, .mem_ack, .mem_rdata, .q_take, .mem_rd, .mem_addr, .pc,
    .acc8, .idx16, .br_taken, .redirect, .instr_done, .bad_opcode);
  boam_partner p_u (.sys_clk, .nrst, .pc_set, .pc_set_val, .q_take,
    .redirect, .pc, .mem_rd, .mem_addr, .q_valid, .q_data, .mem_ack,
    .mem_rdata);

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (mem_rd && mem_ack) begin
    if (acks == 0) ack_addr_r = mem_addr;
    acks++;
  end

  task automatic results();
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, s);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic [15:0] pick();
    return a_fix != 16'h0000 ? a_fix : 16'h1000 + 16'($urandom_range(0, 12287));
  endfunction

  function automatic logic cond_ok(input logic [3:0] x, f);
    logic nv;
    nv = f[boam_pkg::N_BIT] ^ f[boam_pkg::V_BIT];
    case (x[3:1])
      3'h0: return x[0] ^ 1'b1;
      3'h1: return x[0] ^ !(f[boam_pkg::C_BIT] | f[boam_pkg::Z_BIT]);
      3'h2: return x[0] ^ !f[boam_pkg::C_BIT];
      3'h3: return x[0] ^ !f[boam_pkg::Z_BIT];
      3'h4: return x[0] ^ !f[boam_pkg::V_BIT];
      3'h5: return x[0] ^ !f[boam_pkg::N_BIT];
      3'h6: return x[0] ^ !nv;
      default: return x[0] ^ !(f[boam_pkg::Z_BIT] | nv);
    endcase
  endfunction

  task automatic run();
    int k;
    for (k = 0; k < n; k++) p_u.mem[a + 16'(k)] = b[k];
    pc_set = 1'b1;
    pc_set_val = a;
    @(posedge sys_clk);
    #1 pc_set = 1'b0;
    acks = 0;
    k = 0;
    while ((kd == 3 ? bad_opcode : instr_done) !== 1'b1 && k < 100) begin
      @(posedge sys_clk);
      #1 k++;
    end
    if (k == 100) begin
      fails++;
      results();
    end else if (kd == 3) begin
      chk("bad_opcode", 16'h0001, {15'h0, bad_opcode});
    end else begin
      chk("pc", epc, pc);
      chk("br_taken", {15'h0, eb}, {15'h0, br_taken});
      chk("redirect", {15'h0, er}, {15'h0, redirect});
      chk("reads", 16'(ea), 16'(acks));
      if (ea > 0) chk("mem_addr", eadr, ack_addr_r);
      if (kd == 1) chk("acc8", ev, {8'h00, acc8});
      if (kd == 2) chk("idx16", ev, idx16);
    end
  endtask

  task automatic ld(input logic [7:0] op, input logic [15:0] adr);
    logic [7:0] d0, d1;
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    a = pick();
    ccr_flags = 4'($urandom);
    if (op[5:4] == 2'h1) adr = {boam_pkg::ZP_HI, adr[7:0]};
    p_u.mem[adr] = d0;
    p_u.mem[adr + 16'h0001] = d1;
    case (op[5:4])
      2'h0: b = '{op, d0, d1, 8'h00, 8'h00, 8'h00};
      2'h1: b = '{op, adr[7:0], 8'h00, 8'h00, 8'h00, 8'h00};
      default: b = '{op, adr[15:8], adr[7:0], 8'h00, 8'h00, 8'h00};
    endcase
    n = op[5] ? 3 : (op[4] ? 2 : 2 + int'(op[6]));
    kd = op[6] ? 2 : 1;
    ev = op[6] ? {d0, d1} : {8'h00, d0};
    ea = op[5:4] == 2'h0 ? 0 : 1 + int'(op[6]);
    {epc, eb, er, eadr} = {a + 16'(n), 2'b00, adr};
    run();
  endtask

  task automatic br(input logic lng, input logic [3:0] x,
                    input logic [15:0] disp);
    a = pick();
    ccr_flags = 4'($urandom);
    eb = cond_ok(x, ccr_flags);
    if (lng) b = '{boam_pkg::OPC_LONG_PREFIX, {boam_pkg::BR_GROUP, x},
                   disp[15:8], disp[7:0], 8'h00, 8'h00};
    else b = '{{boam_pkg::BR_GROUP, x}, disp[7:0], 8'h00, 8'h00, 8'h00, 8'h00};
    n = lng ? 4 : 2;
    if (!lng) disp = {{8{disp[7]}}, disp[7:0]};
    epc = a + 16'(n) + (eb ? disp : 16'h0000);
    er = eb && disp != 16'h0000;
    {kd, ea} = {32'd0, 32'd0};
    run();
  endtask

  task automatic bit_br(input logic [7:0] op, mask, dat, disp);
    a = pick();
    eadr = op[4] ? 16'h8000 | 16'($urandom) : {8'h00, 8'($urandom)};
    p_u.mem[eadr] = dat;
    if (op[4]) b = '{op, eadr[15:8], eadr[7:0], mask, disp, 8'h00};
    else b = '{op, eadr[7:0], mask, disp, 8'h00, 8'h00};
    n = op[4] ? 5 : 4;
    eb = op[0] ? (dat & mask) == 8'h00 : (dat & mask) == mask;
    epc = a + 16'(n) + (eb ? {{8{disp[7]}}, disp} : 16'h0000);
    er = eb && disp != 8'h00;
    {kd, ea} = {32'd0, 32'd1};
    run();
  endtask

  initial begin
    logic [7:0] lop [6];
    logic [7:0] bop [4];
    lop = '{boam_pkg::OPC_LD8_IMM, boam_pkg::OPC_LD8_DIR,
            boam_pkg::OPC_LD8_EXT, boam_pkg::OPC_LD16_IMM,
            boam_pkg::OPC_LD16_DIR, boam_pkg::OPC_LD16_EXT};
    bop = '{boam_pkg::OPC_BSET_DIR, boam_pkg::OPC_BCLR_DIR,
            boam_pkg::OPC_BSET_EXT, boam_pkg::OPC_BCLR_EXT};
    {sys_clk, nrst, pc_set, pc_set_val, ccr_flags, a_fix} = '0;
    {fails, samples_checked, acks} = '0;
    i = $urandom(32'hc4bda564);
    repeat (10) @(posedge sys_clk);
    #1 nrst = 1'b1;
    for (i = 0; i < 30; i++) ld(lop[i % 6], 16'h8000 | 16'($urandom));
    ld(boam_pkg::OPC_LD16_DIR, 16'h00ff);
    ld(boam_pkg::OPC_LD16_EXT, 16'hffff);
    for (i = 0; i < 32; i++) br(1'b0, 4'(i), 16'($urandom));
    for (i = 0; i < 16; i++) br(1'b1, 4'(i), 16'($urandom));
    br(1'b0, 4'h0, 16'h0000);
    br(1'b1, 4'h1, 16'h0000);
    br(1'b0, 4'h0, 16'h0080);
    br(1'b0, 4'h0, 16'h007f);
    br(1'b0, 4'h0, 16'h00fe);
    br(1'b1, 4'h0, 16'hfffc);
    br(1'b1, 4'h0, 16'h8000);
    a_fix = 16'hfff0;
    br(1'b1, 4'h0, 16'h7fff);
    a_fix = 16'h0000;
    for (i = 0; i < 16; i++) begin
      bit_br(bop[i % 4], 8'($urandom), 8'($urandom), 8'($urandom));
    end
    bit_br(boam_pkg::OPC_BSET_DIR, 8'h03, 8'hff, 8'hfc);
    bit_br(boam_pkg::OPC_BCLR_EXT, 8'h81, 8'h7e, 8'hfb);
    bit_br(boam_pkg::OPC_BCLR_DIR, 8'h03, 8'h01, 8'h10);
    bit_br(boam_pkg::OPC_BSET_EXT, 8'hf0, 8'h70, 8'h22);
    a = pick();
    b = '{boam_pkg::OPC_LONG_PREFIX, boam_pkg::OPC_LD8_IMM, 8'h00, 8'h00,
          8'h00, 8'h00};
    {n, kd} = {32'd2, 32'd3};
    run();
    a = pick();
    b[0] = 8'h01;
    run();
    results();
  end
endmodule

bind boam_core boam_checker chk_u (.sys_clk, .nrst, .pc_set, .q_valid,
  .q_take, .mem_rd, .mem_ack, .mem_addr, .pc, .br_taken, .redirect,
  .instr_done);
